// >>> design/vlim_defines.svh
// Command codes, reset values and field positions of the limit bank
`ifndef VLIM_DEFINES_SVH
`define VLIM_DEFINES_SVH
`define CMD_OUT_FORMAT 8'h20
`define CMD_OUT_SETPOINT 8'h21
`define CMD_OUT_CEILING 8'h24
`define CMD_OUT_MARGIN_HIGH 8'h25
`define CMD_OUT_MARGIN_LOW 8'h26
`define CMD_IN_START 8'h35
`define CMD_IN_STOP 8'h36
`define CMD_OUT_OV_FAULT 8'h40
`define CMD_OUT_OV_WARN 8'h42
`define CMD_OUT_UV_WARN 8'h43
`define CMD_OUT_UV_FAULT 8'h44
`define CMD_IN_OV_FAULT 8'h55
`define CMD_IN_UV_WARN 8'h58
`define CMD_OUT_UPPER_BOUND 8'ha5
`define CMD_OUT_LOAD_LINE 8'hd3
`define RST_OUT_FORMAT 8'h14
`define RST_OUT_SETPOINT 16'h1000
`define RST_OUT_CEILING 16'h5800
`define RST_OUT_MARGIN_HIGH 16'h10cd
`define RST_OUT_MARGIN_LOW 16'h0f33
`define RST_IN_START 16'hcb40
`define RST_IN_STOP 16'hcb00
`define RST_OUT_OV_FAULT 16'h119a
`define RST_OUT_OV_WARN 16'h1133
`define RST_OUT_UV_WARN 16'h0ecd
`define RST_OUT_UV_FAULT 16'h0e66
`define RST_IN_OV_FAULT 16'hd3e0
`define RST_IN_UV_WARN 16'hcb26
`define RST_OUT_UPPER_BOUND 16'h599a
`define RST_OUT_LOAD_LINE 16'h8000
`define L11_EXP_MSB 15
`define L11_EXP_LSB 11
`define L11_MANT_MSB 10
`define WORD_INPUT_BIT 13
`define WORD_VOUT_BIT 15
`define INPUT_UV_WARN_BIT 5
`define OUTPUT_VOLTAGE_CEILING_WARN_BIT 3
`endif

// >>> design/vlim_pkg.sv
// Types shared by the voltage limit bank
package vlim_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] data;
    logic page;
  } cmd_type;
  typedef struct packed {
    logic valid;
    logic [15:0] data;
    logic cml;
  } resp_type;
  typedef enum logic [1:0] {RAMP_IDLE, RAMP_BUSY} ramp_type;
endpackage

// >>> design/l11_compare.sv
// Compare a sample against a linear-eleven threshold
`timescale 1ns/1ps
`default_nettype none
`include "vlim_defines.svh"
module l11_compare
(
  // Operands, both linear-eleven
  input wire logic [15:0] sample,
  input wire logic [15:0] limit,
  // Result
  output logic above
);
  logic signed [47:0] sample_val;
  logic signed [47:0] limit_val;
  // Scale mantissa by exponent offset of 16
  function automatic logic signed [47:0] l11_value(input logic [15:0] w);
    logic signed [4:0] e;
    logic signed [47:0] m;
    logic [5:0] sh;
    e = w[`L11_EXP_MSB:`L11_EXP_LSB];
    m = 48'(signed'(w[`L11_MANT_MSB:0]));
    sh = 6'(e + 6'sd16);
    l11_value = m <<< sh;
  endfunction
  assign sample_val = l11_value(sample); // R18
  assign limit_val = l11_value(limit);
  assign above = sample_val > limit_val;
endmodule
`default_nettype wire

// >>> design/vlim_bank.sv
// Voltage set point and limit command bank, two output channels
//
// Behaviour
// [R1] Start conversion once input reaches start threshold
// [R2] Stop conversion when input falls to stop
// [R3] Input above overvoltage limit declares fault
// [R4] Undervoltage warning armed after start and enable
// [R5] Warning sets summary, input bit, alert
// [R6] Output format byte reads fixed exponent
// [R7] Writing output format raises CML fault
// [R8] Set point per channel, no-load under load-line
// [R9] Defer set point during ramp, else slew
// [R10] Read-only upper bound word, one shared by all channels
// [R11] Writable ceiling bounds set point, margins, OV fault and target
// [R12] Host keeps margin high above set point
// [R13] Host keeps margin low below set point
// [R14] Overvoltage fault and warn limits kept
// [R15] Undervoltage warn and fault limits kept
// [R16] Load-line percent word, default zero
// [R17] Over-ceiling value clamps, warns, alerts
// [R18] Linear-eleven and unsigned sixteen word coding
`timescale 1ns/1ps
`default_nettype none
`include "vlim_defines.svh"
module vlim_bank
  import vlim_pkg::*;
#(
  parameter int CHANNELS = 2,
  parameter logic [15:0] SLEW_STEP = 16'h0001
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Command port from the serial front end
  input wire cmd_type cmd,
  output resp_type resp,
  // Measurements and controls
  input wire logic [15:0] input_voltage,
  input wire logic unit_enable,
  input wire logic alert_mask,
  input wire logic [CHANNELS-1:0] ramp_active,
  input wire logic [CHANNELS-1:0] margin_high_sel,
  input wire logic [CHANNELS-1:0] margin_low_sel,
  // Status and outputs
  output logic conversion_on,
  output logic input_ov_fault,
  output logic [15:0] status_word,
  output logic [7:0] status_input,
  output logic [7:0] status_vout [CHANNELS],
  output logic alert,
  output logic [15:0] output_target [CHANNELS]
);
  // ==========================================================
  // Global input commands
  logic [15:0] input_start_threshold;
  logic [15:0] input_stop_threshold;
  logic [15:0] input_overvoltage_fault_level;
  logic [15:0] input_undervoltage_warn_level;
  logic uv_armed;
  logic above_start;
  logic above_stop;
  logic above_ov;
  logic above_uvw;
  logic wr_en;
  logic rd_en;
  assign wr_en = cmd.wr;
  assign rd_en = cmd.rd;
  l11_compare cmp_start
  (
    .sample(input_voltage),
    .limit(input_start_threshold),
    .above(above_start)
  );
  l11_compare cmp_stop
  (
    .sample(input_voltage),
    .limit(input_stop_threshold),
    .above(above_stop)
  );
  l11_compare cmp_ov
  (
    .sample(input_voltage),
    .limit(input_overvoltage_fault_level),
    .above(above_ov)
  );
  l11_compare cmp_uvw
  (
    .sample(input_voltage),
    .limit(input_undervoltage_warn_level),
    .above(above_uvw)
  );
  logic at_start;
  logic uv_trip;
  assign at_start = above_start || input_voltage == input_start_threshold;
  assign uv_trip = uv_armed && !above_uvw; // R4
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      input_start_threshold <= `RST_IN_START;
      input_stop_threshold <= `RST_IN_STOP;
      input_overvoltage_fault_level <= `RST_IN_OV_FAULT;
      input_undervoltage_warn_level <= `RST_IN_UV_WARN;
    end
    else if (wr_en)
    begin
      case (cmd.code)
        `CMD_IN_START: input_start_threshold <= cmd.data;
        `CMD_IN_STOP: input_stop_threshold <= cmd.data;
        `CMD_IN_OV_FAULT: input_overvoltage_fault_level <= cmd.data;
        `CMD_IN_UV_WARN: input_undervoltage_warn_level <= cmd.data;
        default: ;
      endcase
    end
  end
  // ==========================================================
  // Conversion gating and input faults
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      conversion_on <= 1'b0;
      input_ov_fault <= 1'b0;
      uv_armed <= 1'b0;
    end
    else
    begin
      if (!conversion_on && at_start)
        conversion_on <= 1'b1; // R1
      else if (conversion_on && !above_stop)
        conversion_on <= 1'b0; // R2
      input_ov_fault <= above_ov; // R3
      if (at_start && unit_enable)
        uv_armed <= 1'b1; // R4
      else if (!unit_enable)
        uv_armed <= 1'b0;
    end
  end
  // ==========================================================
  // Per-channel output commands
  logic [15:0] output_voltage_setpoint [CHANNELS];
  logic [15:0] output_voltage_ceiling [CHANNELS];
  logic [15:0] output_margin_high_value [CHANNELS];
  logic [15:0] output_margin_low_value [CHANNELS];
  logic [15:0] output_overvoltage_fault_level [CHANNELS];
  logic [15:0] output_overvoltage_warn_level [CHANNELS];
  logic [15:0] output_undervoltage_warn_level [CHANNELS];
  logic [15:0] output_undervoltage_fault_level [CHANNELS];
  logic [15:0] output_load_line_percent [CHANNELS];
  logic [15:0] active_setpoint [CHANNELS];
  logic [CHANNELS-1:0] vmax_warn;
  logic [15:0] output_command_upper_bound;
  assign output_command_upper_bound = `RST_OUT_UPPER_BOUND; // R10
  // Clamp a value to a bound: the channel ceiling, or the upper bound for ceiling writes
  function automatic logic [15:0] clamp(input logic [15:0] v,
    input logic [15:0] c);
    clamp = (v > c) ? c : v;
  endfunction
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1)
    begin : g_chan
      logic sel;
      logic [15:0] ceil_new;
      logic [15:0] target_sel;
      logic over;
      assign sel = cmd.page == 1'(ch);
      assign ceil_new = clamp(cmd.data, output_command_upper_bound);
      assign over = wr_en && sel && cmd.data > output_voltage_ceiling[ch]
        && (cmd.code == `CMD_OUT_SETPOINT
        || cmd.code == `CMD_OUT_MARGIN_HIGH
        || cmd.code == `CMD_OUT_MARGIN_LOW
        || cmd.code == `CMD_OUT_OV_FAULT); // R17
      assign target_sel = margin_high_sel[ch] ? output_margin_high_value[ch]
        : margin_low_sel[ch] ? output_margin_low_value[ch]
        : output_voltage_setpoint[ch]; // R12 R13
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          output_voltage_setpoint[ch] <= `RST_OUT_SETPOINT;
          output_voltage_ceiling[ch] <= `RST_OUT_CEILING;
          output_margin_high_value[ch] <= `RST_OUT_MARGIN_HIGH;
          output_margin_low_value[ch] <= `RST_OUT_MARGIN_LOW;
          output_overvoltage_fault_level[ch] <= `RST_OUT_OV_FAULT;
          output_overvoltage_warn_level[ch] <= `RST_OUT_OV_WARN;
          output_undervoltage_warn_level[ch] <= `RST_OUT_UV_WARN;
          output_undervoltage_fault_level[ch] <= `RST_OUT_UV_FAULT;
          output_load_line_percent[ch] <= `RST_OUT_LOAD_LINE;
        end
        else if (wr_en && sel)
        begin
          case (cmd.code)
            `CMD_OUT_SETPOINT: output_voltage_setpoint[ch] <=
              clamp(cmd.data, output_voltage_ceiling[ch]); // R8 R17
            `CMD_OUT_CEILING: output_voltage_ceiling[ch] <= ceil_new; // R11
            `CMD_OUT_MARGIN_HIGH: output_margin_high_value[ch] <=
              clamp(cmd.data, output_voltage_ceiling[ch]);
            `CMD_OUT_MARGIN_LOW: output_margin_low_value[ch] <=
              clamp(cmd.data, output_voltage_ceiling[ch]);
            `CMD_OUT_OV_FAULT: output_overvoltage_fault_level[ch] <=
              clamp(cmd.data, output_voltage_ceiling[ch]); // R14
            `CMD_OUT_OV_WARN: output_overvoltage_warn_level[ch] <=
              cmd.data; // R14
            `CMD_OUT_UV_WARN: output_undervoltage_warn_level[ch] <=
              cmd.data; // R15
            `CMD_OUT_UV_FAULT: output_undervoltage_fault_level[ch] <=
              cmd.data; // R15
            `CMD_OUT_LOAD_LINE: output_load_line_percent[ch] <=
              cmd.data; // R16
            default: ;
          endcase
        end
      end
      // Slew toward selected value once no ramp runs
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          active_setpoint[ch] <= `RST_OUT_SETPOINT;
          output_target[ch] <= `RST_OUT_SETPOINT;
          vmax_warn[ch] <= 1'b0;
        end
        else
        begin
          if (ramp_active[ch])
            active_setpoint[ch] <= active_setpoint[ch]; // R9
          else
            active_setpoint[ch] <= clamp(target_sel,
              output_voltage_ceiling[ch]); // R11
          if (ramp_active[ch])
            output_target[ch] <= output_target[ch]; // R9
          else if (output_target[ch] > output_voltage_ceiling[ch])
            output_target[ch] <= output_voltage_ceiling[ch]; // R11
          else if (output_target[ch] + SLEW_STEP < active_setpoint[ch])
            output_target[ch] <= output_target[ch] + SLEW_STEP; // R9
          else if (output_target[ch] > active_setpoint[ch] + SLEW_STEP)
            output_target[ch] <= output_target[ch] - SLEW_STEP;
          else
            output_target[ch] <= active_setpoint[ch];
          if (over)
            vmax_warn[ch] <= 1'b1; // R17
        end
      end
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
          status_vout[ch] <= 8'h00;
        else
          status_vout[ch] <= {4'h0, vmax_warn[ch] | over, 3'h0}; // R17
      end
    end
  endgenerate
  // ==========================================================
  // Read mux
  logic sel_page;
  logic [15:0] rd_data;
  logic cml_hit;
  assign sel_page = cmd.page;
  assign cml_hit = wr_en && (cmd.code == `CMD_OUT_FORMAT
    || cmd.code == `CMD_OUT_UPPER_BOUND); // R7
  always_comb
  begin
    rd_data = 16'h0000;
    case (cmd.code)
      `CMD_OUT_FORMAT: rd_data = {8'h00, 8'(`RST_OUT_FORMAT)}; // R6
      `CMD_OUT_SETPOINT: rd_data = output_voltage_setpoint[sel_page];
      `CMD_OUT_CEILING: rd_data = output_voltage_ceiling[sel_page];
      `CMD_OUT_MARGIN_HIGH: rd_data = output_margin_high_value[sel_page];
      `CMD_OUT_MARGIN_LOW: rd_data = output_margin_low_value[sel_page];
      `CMD_IN_START: rd_data = input_start_threshold;
      `CMD_IN_STOP: rd_data = input_stop_threshold;
      `CMD_OUT_OV_FAULT: rd_data = output_overvoltage_fault_level[sel_page];
      `CMD_OUT_OV_WARN: rd_data = output_overvoltage_warn_level[sel_page];
      `CMD_OUT_UV_WARN: rd_data = output_undervoltage_warn_level[sel_page];
      `CMD_OUT_UV_FAULT: rd_data = output_undervoltage_fault_level[sel_page];
      `CMD_IN_OV_FAULT: rd_data = input_overvoltage_fault_level;
      `CMD_IN_UV_WARN: rd_data = input_undervoltage_warn_level;
      `CMD_OUT_UPPER_BOUND: rd_data = output_command_upper_bound; // R10
      `CMD_OUT_LOAD_LINE: rd_data = output_load_line_percent[sel_page];
      default: rd_data = 16'h0000;
    endcase
  end
  // ==========================================================
  // Status and alert
  logic uv_warn;
  logic any_vmax;
  assign any_vmax = |vmax_warn;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      resp <= '0;
      uv_warn <= 1'b0;
      status_word <= 16'h0000;
      status_input <= 8'h00;
      alert <= 1'b0;
    end
    else
    begin
      resp.valid <= rd_en || wr_en;
      resp.data <= rd_en ? rd_data : 16'h0000;
      resp.cml <= cml_hit; // R7
      if (uv_trip)
        uv_warn <= 1'b1; // R5
      status_word <= {any_vmax, 1'b0, uv_warn, 13'h0000}; // R5 R17
      status_input <= {2'b00, uv_warn, 5'h00}; // R5
      alert <= (uv_warn || any_vmax) && !alert_mask; // R5 R17
    end
  end
  // ==========================================================
  // Checks
  start_gate_a: assert property (@(posedge mclk) disable iff (rst)
    !conversion_on && at_start |=> conversion_on) // R1
    else $error("conversion did not start");
  stop_gate_a: assert property (@(posedge mclk) disable iff (rst)
    conversion_on && !above_stop |=> !conversion_on) // R2
    else $error("conversion did not stop");
  input_ov_a: assert property (@(posedge mclk) disable iff (rst)
    above_ov |=> input_ov_fault) // R3
    else $error("input overvoltage missed");
  uv_arm_a: assert property (@(posedge mclk) disable iff (rst)
    !uv_armed && !uv_warn |=> !uv_warn) // R4
    else $error("warning set while unarmed");
  uv_alert_a: assert property (@(posedge mclk) disable iff (rst)
    uv_trip && !alert_mask |=> ##1 alert && status_input[5]) // R5
    else $error("undervoltage warning not reported");
  format_cml_a: assert property (@(posedge mclk) disable iff (rst)
    wr_en && cmd.code == `CMD_OUT_FORMAT |=> resp.cml) // R7
    else $error("format write not flagged");
  format_read_a: assert property (@(posedge mclk) disable iff (rst)
    rd_en && cmd.code == `CMD_OUT_FORMAT |=> resp.data == 16'h0014) // R6
    else $error("format byte wrong");
  ceiling_hold_a: assert property (@(posedge mclk) disable iff (rst)
    output_target[0] <= $past(output_voltage_ceiling[0])
    || $changed(output_voltage_ceiling[0])) // R11
    else $error("output above ceiling");
  ramp_hold_a: assert property (@(posedge mclk) disable iff (rst)
    ramp_active[0] |=> $stable(output_target[0])) // R9
    else $error("target moved during ramp");
endmodule
`default_nettype wire

// >>> test/host_model.sv
// Host side model that issues word transfers on the command port
`timescale 1ns/1ps
`default_nettype none
module host_model
  import vlim_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Command port
  output cmd_type cmd,
  input wire resp_type resp
);
  logic [15:0] rd_data;
  logic rd_cml;
  logic got;

  initial cmd = '0;

  // ==========================================
  // One whole word transfer, bounded wait for the answer
  task automatic xfer(input logic wr, input logic [7:0] code,
    input logic [15:0] data, input logic page);
    int n;
    @(posedge mclk);
    #1;
    cmd.wr = wr;
    cmd.rd = ~wr;
    cmd.code = code;
    cmd.data = data;
    cmd.page = page;
    @(posedge mclk);
    #1;
    cmd.wr = 1'b0;
    cmd.rd = 1'b0;
    cmd.data = ~data;
    got = 1'b0;
    rd_data = 16'h0000;
    rd_cml = 1'b0;
    for (n = 0; n < 4 && !got; n++)
    begin
      if (resp.valid === 1'b1)
      begin
        got = 1'b1;
        rd_data = resp.data;
        rd_cml = resp.cml;
      end
      else
      begin
        @(posedge mclk);
        #1;
      end
    end
  endtask

  // ==========================================
  // Margins kept on the right side of the nominal value
  task automatic write_margins(input logic page, input logic [15:0] nom,
    input logic [15:0] high, input logic [15:0] low);
    if (high > nom)
      xfer(1'b1, `CMD_OUT_MARGIN_HIGH, high, page);
    if (low < nom)
      xfer(1'b1, `CMD_OUT_MARGIN_LOW, low, page);
  endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Self-checking bench for the voltage limit command bank
`timescale 1ns/1ps
`default_nettype none
`include "vlim_defines.svh"
module tb_top;
  import vlim_pkg::*;
  logic mclk;
  logic rst;
  cmd_type cmd;
  resp_type resp;
  logic [15:0] input_voltage;
  logic unit_enable;
  logic alert_mask;
  logic [1:0] ramp_active;
  logic [1:0] margin_high_sel;
  logic [1:0] margin_low_sel;
  logic conversion_on;
  logic input_ov_fault;
  logic alert;
  logic [15:0] status_word;
  logic [7:0] status_input;
  logic [7:0] status_vout [2];
  logic [15:0] output_target [2];
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int i;
  logic [7:0] codes [15] = '{8'h20, 8'h21, 8'h24, 8'h25, 8'h26, 8'h35,
    8'h36, 8'h40, 8'h42, 8'h43, 8'h44, 8'h55, 8'h58, 8'ha5, 8'hd3};
  logic [15:0] resets [15] = '{16'h0014, 16'h1000, 16'h5800, 16'h10cd,
    16'h0f33, 16'hcb40, 16'hcb00, 16'h119a, 16'h1133, 16'h0ecd,
    16'h0e66, 16'hd3e0, 16'hcb26, 16'h599a, 16'h8000};

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;

  vlim_bank u_vlim_bank (.mclk(mclk), .rst(rst), .cmd(cmd), .resp(resp),
    .input_voltage(input_voltage), .unit_enable(unit_enable),
    .alert_mask(alert_mask), .ramp_active(ramp_active),
    .margin_high_sel(margin_high_sel), .margin_low_sel(margin_low_sel),
    .conversion_on(conversion_on), .input_ov_fault(input_ov_fault),
    .status_word(status_word), .status_input(status_input),
    .status_vout(status_vout), .alert(alert),
    .output_target(output_target));

  host_model u_host_model (.mclk(mclk), .cmd(cmd), .resp(resp));

  // ==========================================
  // Checks and bus tasks
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] code, input logic page,
    input logic [15:0] exp);
    u_host_model.xfer(1'b0, code, 16'h0000, page);
    check({15'h0000, u_host_model.got}, 16'h0001);
    check(u_host_model.rd_data, exp);
  endtask

  task automatic wr(input logic [7:0] code, input logic [15:0] data,
    input logic page);
    u_host_model.xfer(1'b1, code, data, page);
    check({15'h0000, u_host_model.got}, 16'h0001);
  endtask

  task automatic settle();
    repeat (4) @(posedge mclk);
    #1;
  endtask

  task automatic wait_target(input logic [15:0] v);
    int n;
    for (n = 0; n < 12 && output_target[0] !== v; n++)
    begin
      @(posedge mclk);
      #1;
    end
  endtask

  task automatic do_reset();
    @(posedge mclk);
    #1;
    rst = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    rst = 1'b0;
  endtask

  task automatic report_and_stop();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      report_and_stop();
    end
  end

  // ==========================================
  // Test sequence
  initial
  begin
    rst = 1'b1;
    input_voltage = 16'hcb10;
    unit_enable = 1'b0;
    alert_mask = 1'b1;
    ramp_active = 2'b00;
    margin_high_sel = 2'b00;
    margin_low_sel = 2'b00;
    do_reset();
    check(output_target[0], `RST_OUT_SETPOINT);
    for (i = 0; i < 30; i++)
      rd(codes[i % 15], 1'(i / 15), resets[i % 15]);
    rd(8'h99, 1'b0, 16'h0000);
    $display("test reset_values done");
    wr(`CMD_OUT_FORMAT, 16'h00ff, 1'b0);
    check({15'h0000, u_host_model.rd_cml}, 16'h0001);
    rd(`CMD_OUT_FORMAT, 1'b0, 16'h0014);
    wr(`CMD_OUT_UPPER_BOUND, 16'h1234, 1'b0);
    check({15'h0000, u_host_model.rd_cml}, 16'h0001);
    rd(`CMD_OUT_UPPER_BOUND, 1'b0, `RST_OUT_UPPER_BOUND);
    wr(`CMD_OUT_OV_FAULT, 16'h1200, 1'b1);
    rd(`CMD_OUT_OV_FAULT, 1'b1, 16'h1200);
    rd(`CMD_OUT_OV_FAULT, 1'b0, `RST_OUT_OV_FAULT);
    wr(`CMD_OUT_UV_FAULT, 16'h0e00, 1'b1);
    rd(`CMD_OUT_UV_FAULT, 1'b1, 16'h0e00);
    wr(`CMD_OUT_LOAD_LINE, 16'h0801, 1'b1);
    rd(`CMD_OUT_LOAD_LINE, 1'b1, 16'h0801);
    u_host_model.write_margins(1'b0, 16'h1000, 16'h1100, 16'h0f00);
    rd(`CMD_OUT_MARGIN_HIGH, 1'b0, 16'h1100);
    rd(`CMD_OUT_MARGIN_LOW, 1'b0, 16'h0f00);
    $display("test write_refuse done");
    settle();
    check({15'h0000, conversion_on}, 16'h0000);
    input_voltage = 16'hcb50;
    settle();
    check({15'h0000, conversion_on}, 16'h0001);
    input_voltage = 16'hcb10;
    settle();
    check({15'h0000, conversion_on}, 16'h0001);
    check({8'h00, status_input}, 16'h0000);
    input_voltage = 16'hcaf0;
    settle();
    check({15'h0000, conversion_on}, 16'h0000);
    check({15'h0000, input_ov_fault}, 16'h0000);
    input_voltage = 16'hd3f0;
    settle();
    check({15'h0000, input_ov_fault}, 16'h0001);
    unit_enable = 1'b1;
    input_voltage = 16'hcb50;
    settle();
    check({15'h0000, input_ov_fault}, 16'h0000);
    check({8'h00, status_input}, 16'h0000);
    input_voltage = 16'hcb10;
    settle();
    check({8'h00, status_input}, 16'h0020);
    check({15'h0000, status_word[13]}, 16'h0001);
    check({15'h0000, alert}, 16'h0000);
    $display("test input_limits done");
    alert_mask = 1'b0;
    input_voltage = 16'hcb50;
    do_reset();
    wr(`CMD_OUT_CEILING, 16'h6000, 1'b1);
    rd(`CMD_OUT_CEILING, 1'b1, `RST_OUT_UPPER_BOUND);
    wr(`CMD_OUT_CEILING, 16'h2000, 1'b1);
    wr(`CMD_OUT_SETPOINT, 16'h3000, 1'b1);
    rd(`CMD_OUT_SETPOINT, 1'b1, 16'h2000);
    settle();
    check({15'h0000, status_vout[1][3]}, 16'h0001);
    check({15'h0000, status_vout[0][3]}, 16'h0000);
    check({15'h0000, status_word[15]}, 16'h0001);
    check({15'h0000, alert}, 16'h0001);
    $display("test ceiling_clamp done");
    ramp_active = 2'b01;
    wr(`CMD_OUT_SETPOINT, 16'h1004, 1'b0);
    settle();
    check(output_target[0], 16'h1000);
    ramp_active = 2'b00;
    repeat (2) @(posedge mclk);
    #1;
    check({15'h0000, output_target[0] == 16'h1004}, 16'h0000);
    wait_target(16'h1004);
    check(output_target[0], 16'h1004);
    u_host_model.write_margins(1'b0, 16'h1004, 16'h1008, 16'h1000);
    margin_high_sel = 2'b01;
    wait_target(16'h1008);
    check(output_target[0], 16'h1008);
    margin_high_sel = 2'b00;
    margin_low_sel = 2'b01;
    wait_target(16'h1000);
    check(output_target[0], 16'h1000);
    $display("test slew done");
    report_and_stop();
  end
endmodule
`default_nettype wire
